// ### logic/aab_pkg.sv
// Shared constants and types for the accumulator ALU and bit-operation block.
// Assumes one core clock and a decoder that presents one decoded instruction per cycle.
package aab_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned FILE_DEPTH = 128;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_ACC = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_FADDR = 8'h0c;
  localparam logic [7:0] REG_FDATA = 8'h10;

  // Field positions
  localparam int unsigned FLAG_C_POS = 0;
  localparam int unsigned FLAG_DC_POS = 1;
  localparam int unsigned FLAG_Z_POS = 2;
  localparam int unsigned CTRL_PSA_POS = 0;

  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic CTRL_PSA_RESET = 1'b0;
  localparam logic [6:0] FPTR_RESET = 7'h00;

  // Special file locations
  localparam logic [6:0] TIMER_ADDR = 7'h01;
  localparam logic [6:0] PORT_ADDR = 7'h05;

  // Timing: a taken skip occupies this many instruction cycles
  localparam int unsigned SKIP_CYCLES = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    AAB_OP_NOP = 9'h001,
    AAB_OP_ADD_IMM = 9'h002,
    AAB_OP_ADD_FILE = 9'h004,
    AAB_OP_AND_IMM = 9'h008,
    AAB_OP_AND_FILE = 9'h010,
    AAB_OP_CLR_BIT = 9'h020,
    AAB_OP_SET_BIT = 9'h040,
    AAB_OP_SKIP_LOW = 9'h080,
    AAB_OP_SKIP_HIGH = 9'h100
  } aab_op_t;

  typedef struct packed {
    aab_op_t op;
    logic [6:0] faddr;
    logic dest;
    logic [2:0] bsel;
    logic [7:0] lit;
  } aab_instr_t;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } aab_flags_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } aab_apb_req_t;

endpackage

// ### logic/aab_core.sv
// Accumulator ALU and bit-operation datapath with its file registers and APB window.
// Assumes the decoder issues at most one instruction per MCLK cycle on INSTR_VALID.
//
// How it works
// - Add immediate adds literal to accumulator, result to accumulator, sets Z C DC.
// - Add with file adds addressed file register to accumulator, sets Z C DC.
// - For add and AND with file, destination bit 0 writes accumulator, 1 writes the addressed file register.
// - AND immediate ANDs literal into accumulator, changing only the zero flag.
// - AND with file ANDs file register, result to destination, only zero flag.
// - Clear bit forces chosen bit of file register low, flags untouched.
// - Set bit forces chosen bit of file register high, flags untouched.
// - Skip-if-low squashes the next instruction into a nop when tested bit is zero.
// - Skip-if-high squashes the next instruction into a nop when tested bit is one.
// - Skip tests never change the tested register or any flag.
// - Read-modify-write of the port register reads pin levels, not the latch.
// - Writing the timer count clears the prescaler when assigned to the timer; writes to it through the APB window (REG_FDATA) do not.
//
// Added by the designer: the APB register port and the placing of the registers.
module aab_core (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_B,
  // APB slave
  input wire aab_pkg::aab_apb_req_t APB_REQ,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Instruction issue from the decoder
  input wire logic INSTR_VALID,
  input wire aab_pkg::aab_instr_t INSTR,
  // Pins and side effects
  input wire logic [7:0] PIN_LEVELS,
  output logic [7:0] ACC_VALUE,
  output aab_pkg::aab_flags_t FLAGS,
  output logic SKIP_SLOT,
  output logic PRESCALE_CLR,
  output logic [7:0] PORT_LATCH
);
  import aab_pkg::*;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------

  // One-hot mask for a bit number
  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    return 8'h01 << b;
  endfunction

  // Operand fetch: the port location returns the pin levels
  function automatic logic [7:0] rmw_read(input logic [6:0] a, input logic [7:0] stored,
                                          input logic [7:0] pins);
    return (a == PORT_ADDR) ? pins : stored;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] acc, next_acc;
  aab_flags_t flags, next_flags;
  logic [7:0] file_mem [FILE_DEPTH];
  logic [7:0] next_file_mem [FILE_DEPTH];
  logic skip, next_skip;
  logic pclr, next_pclr;
  logic ctrl_psa, next_ctrl_psa;
  logic [6:0] fptr, next_fptr;
  logic [31:0] rdata, next_rdata;
  logic ready, next_ready;
  logic slverr, next_slverr;

  // Execute-stage signals
  logic live;
  logic [7:0] fval;
  logic [7:0] operand;
  logic [8:0] sum9;
  logic [4:0] lo5;
  logic [7:0] and_r;
  logic [7:0] result;
  logic tested;
  logic is_add, is_and, is_file_alu;
  logic apb_setup, apb_wr;

  // ----------------------------------------------------------------
  // Execute datapath
  // ----------------------------------------------------------------

  // Operand select and arithmetic
  always_comb
  begin
    live = INSTR_VALID && !skip;
    is_add = (INSTR.op == AAB_OP_ADD_IMM) || (INSTR.op == AAB_OP_ADD_FILE);
    is_and = (INSTR.op == AAB_OP_AND_IMM) || (INSTR.op == AAB_OP_AND_FILE);
    is_file_alu = (INSTR.op == AAB_OP_ADD_FILE) || (INSTR.op == AAB_OP_AND_FILE);
    fval = rmw_read(INSTR.faddr, file_mem[INSTR.faddr], PIN_LEVELS);
    operand = is_file_alu ? fval : INSTR.lit;
    sum9 = {1'b0, acc} + {1'b0, operand};
    lo5 = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
    and_r = acc & operand;
    result = is_add ? sum9[7:0] : and_r;
    tested = |(fval & bit_mask(INSTR.bsel));
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  always_comb
  begin
    apb_setup = APB_REQ.psel && !APB_REQ.penable;
    apb_wr = APB_REQ.psel && APB_REQ.penable && ready && APB_REQ.pwrite;
  end

  // Read data, ready and error are prepared in the setup cycle
  always_comb
  begin
    next_ready = apb_setup;
    next_slverr = 1'b0;
    next_rdata = 32'h0000_0000;
    if (apb_setup)
    begin
      case (APB_REQ.paddr)
        REG_ACC: next_rdata = {24'h00_0000, acc};
        REG_FLAGS: next_rdata = {29'h0000_0000, flags};
        REG_CTRL: next_rdata = {31'h0000_0000, ctrl_psa};
        REG_FADDR: next_rdata = {25'h000_0000, fptr};
        REG_FDATA: next_rdata = {24'h00_0000, file_mem[fptr]};
        default: next_slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rdata <= 32'h0000_0000;
      ready <= 1'b0;
      slverr <= 1'b0;
    end
    else
    begin
      rdata <= next_rdata;
      ready <= next_ready;
      slverr <= next_slverr;
    end
  end

  // ----------------------------------------------------------------
  // Architectural state update
  // ----------------------------------------------------------------

  // Accumulator, flags, file and control; instructions win over APB writes
  always_comb
  begin
    next_acc = acc;
    next_flags = flags;
    next_file_mem = file_mem;
    next_ctrl_psa = ctrl_psa;
    next_fptr = fptr;
    next_skip = skip;
    next_pclr = 1'b0;
    // Software access through the window
    if (apb_wr)
    begin
      case (APB_REQ.paddr)
        REG_ACC: next_acc = APB_REQ.pwdata[7:0];
        REG_FLAGS: next_flags = APB_REQ.pwdata[2:0];
        REG_CTRL: next_ctrl_psa = APB_REQ.pwdata[CTRL_PSA_POS];
        REG_FADDR: next_fptr = APB_REQ.pwdata[6:0];
        REG_FDATA: next_file_mem[fptr] = APB_REQ.pwdata[7:0];
        default: next_ctrl_psa = ctrl_psa;
      endcase
    end
    if (INSTR_VALID && skip)
    begin
      next_skip = 1'b0;
    end
    if (live)
    begin
      case (INSTR.op)
        AAB_OP_ADD_IMM, AAB_OP_ADD_FILE, AAB_OP_AND_IMM, AAB_OP_AND_FILE:
        begin
          if (is_file_alu && INSTR.dest)
          begin
            next_file_mem[INSTR.faddr] = result;
          end
          else
          begin
            next_acc = result;
          end
          next_flags.z = (result == 8'h00);
          if (is_add)
          begin
            next_flags.c = sum9[8];
            next_flags.dc = lo5[4];
          end
          next_pclr = is_file_alu && INSTR.dest && (INSTR.faddr == TIMER_ADDR) && ctrl_psa;
        end
        AAB_OP_CLR_BIT:
        begin
          next_file_mem[INSTR.faddr] = fval & ~bit_mask(INSTR.bsel);
          next_pclr = (INSTR.faddr == TIMER_ADDR) && ctrl_psa;
        end
        AAB_OP_SET_BIT:
        begin
          next_file_mem[INSTR.faddr] = fval | bit_mask(INSTR.bsel);
          next_pclr = (INSTR.faddr == TIMER_ADDR) && ctrl_psa;
        end
        AAB_OP_SKIP_LOW:
        begin
          next_skip = !tested;
        end
        AAB_OP_SKIP_HIGH:
        begin
          next_skip = tested;
        end
        default:
        begin
          next_skip = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      acc <= ACC_RESET;
      flags <= FLAGS_RESET;
      ctrl_psa <= CTRL_PSA_RESET;
      fptr <= FPTR_RESET;
      skip <= 1'b0;
      pclr <= 1'b0;
      for (int i = 0; i < FILE_DEPTH; i++)
      begin
        file_mem[i] <= FILE_RESET;
      end
    end
    else
    begin
      acc <= next_acc;
      flags <= next_flags;
      ctrl_psa <= next_ctrl_psa;
      fptr <= next_fptr;
      skip <= next_skip;
      pclr <= next_pclr;
      file_mem <= next_file_mem;
    end
  end

  // Outputs straight from flip-flops
  always_comb
  begin
    PRDATA = rdata;
    PREADY = ready;
    PSLVERR = slverr;
    ACC_VALUE = acc;
    FLAGS = flags;
    SKIP_SLOT = skip;
    PRESCALE_CLR = pclr;
    PORT_LATCH = file_mem[PORT_ADDR];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  chk_add_imm_sum: assert property (live && INSTR.op == AAB_OP_ADD_IMM |=>
    {flags.c, acc} == $past({1'b0, acc} + {1'b0, INSTR.lit}) && flags.z == (acc == 8'h00)
    && flags.dc == $past(({1'b0, acc[3:0]} + {1'b0, INSTR.lit[3:0]}) > 5'h0f))
    else $error("add immediate result or carries wrong");

  chk_add_file_flags: assert property (live && INSTR.op == AAB_OP_ADD_FILE && !INSTR.dest |=>
    acc == $past(acc) + $past(fval) && flags.z == (acc == 8'h00))
    else $error("add with file result or zero flag wrong");

  chk_dest_file_keep: assert property (live && is_file_alu && INSTR.dest |=>
    acc == $past(acc) && file_mem[$past(INSTR.faddr)] == $past(result))
    else $error("file destination not honoured");

  chk_and_imm_flags: assert property (live && INSTR.op == AAB_OP_AND_IMM |=>
    acc == ($past(acc) & $past(INSTR.lit)) && flags.c == $past(flags.c) && flags.dc == $past(flags.dc))
    else $error("and immediate touched carries or wrong result");

  chk_and_file_acc: assert property (live && INSTR.op == AAB_OP_AND_FILE && !INSTR.dest |=>
    acc == ($past(acc) & $past(fval)) && $stable(flags.c) && $stable(flags.dc))
    else $error("and with file wrong");

  chk_clear_bit: assert property (live && INSTR.op == AAB_OP_CLR_BIT |=>
    !file_mem[$past(INSTR.faddr)][$past(INSTR.bsel)] && $stable(flags) && $stable(acc))
    else $error("bit clear failed or flags changed");

  chk_set_bit: assert property (live && INSTR.op == AAB_OP_SET_BIT |=>
    file_mem[$past(INSTR.faddr)][$past(INSTR.bsel)] && $stable(flags))
    else $error("bit set failed or flags changed");

  chk_skip_low: assert property (live && INSTR.op == AAB_OP_SKIP_LOW |=>
    SKIP_SLOT == !$past(tested))
    else $error("skip-if-low decision wrong");

  chk_skip_high: assert property (live && INSTR.op == AAB_OP_SKIP_HIGH |=>
    SKIP_SLOT == $past(tested))
    else $error("skip-if-high decision wrong");

  chk_skip_squash: assert property (skip && INSTR_VALID && !apb_wr |=>
    !SKIP_SLOT && $stable(acc) && $stable(flags) && !PRESCALE_CLR)
    else $error("skipped slot was not a nop");

  chk_test_no_write: assert property (live && (INSTR.op == AAB_OP_SKIP_LOW || INSTR.op == AAB_OP_SKIP_HIGH)
    && !apb_wr |=> $stable(flags) && $stable(acc) && file_mem[$past(INSTR.faddr)] == $past(file_mem[INSTR.faddr]))
    else $error("bit test modified state");

  chk_port_pins: assert property (live && INSTR.op == AAB_OP_ADD_FILE && INSTR.faddr == PORT_ADDR
    && !INSTR.dest |=> acc == $past(acc) + $past(PIN_LEVELS))
    else $error("port operand did not use pin levels");

  chk_timer_clear: assert property (live && INSTR.faddr == TIMER_ADDR && (INSTR.op == AAB_OP_SET_BIT
    || INSTR.op == AAB_OP_CLR_BIT) |=> PRESCALE_CLR == $past(ctrl_psa))
    else $error("prescaler clear wrong");

  chk_zero_flag: assert property (live && is_and && !INSTR.dest |=> flags.z == (acc == 8'h00))
    else $error("zero flag does not match result");

  chk_apb_ready: assert property (apb_setup |=> PREADY ##1 !PREADY || apb_setup)
    else $error("APB ready timing wrong");

  cov_skip_taken: cover property (live && INSTR.op == AAB_OP_SKIP_HIGH ##1 SKIP_SLOT && INSTR_VALID);
  cov_add_to_file: cover property (live && INSTR.op == AAB_OP_ADD_FILE && INSTR.dest);
  cov_apb_write: cover property (apb_wr && APB_REQ.paddr == REG_ACC);
  cov_prescale: cover property (PRESCALE_CLR);

endmodule

// ### bench/aab_decoder_model.sv
// Stand-in for the instruction decoder that issues one decoded instruction per clock.
// Assumes each task is entered just after a rising MCLK edge.
module aab_decoder_model (
  // Clock
  input wire logic mclk,
  // Issue port
  output aab_pkg::aab_instr_t instr,
  output logic instr_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  import aab_pkg::*;

  // Idle issue port from time zero
  initial
  begin
    instr_valid = 1'b0;
    instr = '0;
  end

  // Present one instruction, taken at the next edge
  task automatic issue(input aab_instr_t i);
    instr_valid <= 1'b1;
    instr <= i;
    @(posedge mclk);
  endtask

  // Release the port; inverted fields keep stale values from looking valid
  task automatic rest();
    instr_valid <= 1'b0;
    instr <= ~instr;
    @(posedge mclk);
  endtask
endmodule

// ### bench/accumulator_alu_and_bit_ops_test.sv
// Self-checking bench for the accumulator ALU and bit-operation datapath.
// Assumes the decoder stand-in model and APB slave timing of the core.
module accumulator_alu_and_bit_ops_test;
  timeunit 1ns;
  timeprecision 1ns;
  import aab_pkg::*;

  typedef struct {
    aab_op_t op;
    logic [6:0] fa;
    logic d;
    logic [2:0] b;
    logic [7:0] k, a0, f0, ea, ef;
    logic [2:0] g0, eg;
    logic sk;
  } aab_row_t;

  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  aab_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, instr_valid, skip_slot, pclr;
  aab_instr_t instr;
  logic [7:0] pins = 8'h0f;
  logic [7:0] acc, latch;
  aab_flags_t flags;
  int errors = 0;
  int compares = 0;
  aab_row_t rows[13];
  logic [31:0] r;
  logic e;
  localparam aab_instr_t NOP_I = '{AAB_OP_NOP, 7'h00, 1'b0, 3'h0, 8'h00};

  // Clock
  always #5 mclk = ~mclk;

  aab_core dut (.MCLK(mclk), .RST_B(rst_b), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .INSTR_VALID(instr_valid), .INSTR(instr), .PIN_LEVELS(pins), .ACC_VALUE(acc),
    .FLAGS(flags), .SKIP_SLOT(skip_slot), .PRESCALE_CLR(pclr), .PORT_LATCH(latch));

  aab_decoder_model seq (.mclk(mclk), .instr(instr), .instr_valid(instr_valid));

  // Compare and count
  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  // APB transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    if (n >= 16)
      errors++;
    req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #100000;
    errors++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rows[0] = '{AAB_OP_ADD_IMM, 7'h7f, 1'b0, 3'h0, 8'h01, 8'h0f, 8'h00, 8'h10, 8'h00, 3'h0, 3'h2, 1'b0};
    rows[1] = '{AAB_OP_ADD_IMM, 7'h7f, 1'b0, 3'h0, 8'h01, 8'hff, 8'h00, 8'h00, 8'h00, 3'h0, 3'h7, 1'b0};
    rows[2] = '{AAB_OP_ADD_IMM, 7'h7f, 1'b0, 3'h0, 8'hff, 8'h80, 8'h00, 8'h7f, 8'h00, 3'h0, 3'h1, 1'b0};
    rows[3] = '{AAB_OP_ADD_FILE, 7'h7f, 1'b0, 3'h0, 8'h00, 8'h22, 8'h11, 8'h33, 8'h11, 3'h7, 3'h0, 1'b0};
    rows[4] = '{AAB_OP_ADD_FILE, 7'h7f, 1'b1, 3'h0, 8'h00, 8'h08, 8'h08, 8'h08, 8'h10, 3'h0, 3'h2, 1'b0};
    rows[5] = '{AAB_OP_AND_IMM, 7'h7f, 1'b0, 3'h0, 8'h0f, 8'hf0, 8'h00, 8'h00, 8'h00, 3'h3, 3'h7, 1'b0};
    rows[6] = '{AAB_OP_AND_FILE, 7'h7f, 1'b1, 3'h0, 8'h00, 8'h3c, 8'hff, 8'h3c, 8'h3c, 3'h7, 3'h3, 1'b0};
    rows[7] = '{AAB_OP_AND_FILE, 7'h7f, 1'b0, 3'h0, 8'h00, 8'hf0, 8'h0f, 8'h00, 8'h0f, 3'h0, 3'h4, 1'b0};
    rows[8] = '{AAB_OP_CLR_BIT, 7'h7f, 1'b0, 3'h7, 8'h00, 8'h55, 8'hff, 8'h55, 8'h7f, 3'h5, 3'h5, 1'b0};
    rows[9] = '{AAB_OP_SET_BIT, 7'h7f, 1'b0, 3'h0, 8'h00, 8'h55, 8'h00, 8'h55, 8'h01, 3'h2, 3'h2, 1'b0};
    rows[10] = '{AAB_OP_SKIP_LOW, 7'h7f, 1'b0, 3'h3, 8'h00, 8'ha0, 8'h08, 8'ha0, 8'h08, 3'h6, 3'h6, 1'b0};
    rows[11] = '{AAB_OP_SKIP_HIGH, 7'h7f, 1'b0, 3'h3, 8'h00, 8'ha0, 8'h08, 8'ha0, 8'h08, 3'h1, 3'h1, 1'b1};
    rows[12] = '{AAB_OP_SKIP_HIGH, 7'h7f, 1'b0, 3'h2, 8'h00, 8'ha0, 8'h08, 8'ha0, 8'h08, 3'h7, 3'h7, 1'b0};
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    cmp("acc reset", ACC_RESET, acc);
    cmp("flags reset", FLAGS_RESET, flags);
    // Table of single instructions
    foreach (rows[i])
    begin
      apb(1'b1, REG_ACC, 32'(rows[i].a0));
      apb(1'b1, REG_FLAGS, 32'(rows[i].g0));
      apb(1'b1, REG_FADDR, 32'(rows[i].fa));
      apb(1'b1, REG_FDATA, 32'(rows[i].f0));
      @(posedge mclk);
      seq.issue('{rows[i].op, rows[i].fa, rows[i].d, rows[i].b, rows[i].k});
      // Row results stand at the edge that takes the following nop
      seq.issue(NOP_I);
      cmp("acc", rows[i].ea, acc);
      cmp("flags", rows[i].eg, flags);
      cmp("skip", rows[i].sk, skip_slot);
      seq.rest();
      apb(1'b0, REG_FDATA, 32'h0);
      cmp("file", rows[i].ef, r);
    end
    // Taken skip squashes the next of three back-to-back instructions
    apb(1'b1, REG_FADDR, 32'h20);
    apb(1'b1, REG_FDATA, 32'h00);
    apb(1'b1, REG_ACC, 32'h10);
    @(posedge mclk);
    seq.issue('{AAB_OP_SKIP_LOW, 7'h20, 1'b0, 3'h5, 8'h00});
    seq.issue('{AAB_OP_ADD_IMM, 7'h20, 1'b0, 3'h0, 8'h05});
    cmp("skip taken", 1'b1, skip_slot);
    seq.issue('{AAB_OP_ADD_IMM, 7'h20, 1'b0, 3'h0, 8'h01});
    seq.rest();
    cmp("acc after skip", 8'h11, acc);
    cmp("skip cleared", 1'b0, skip_slot);
    // Port bit set reads the pins, not the latch
    apb(1'b1, REG_FADDR, 32'(PORT_ADDR));
    apb(1'b1, REG_FDATA, 32'hf0);
    @(posedge mclk);
    seq.issue('{AAB_OP_SET_BIT, PORT_ADDR, 1'b0, 3'h7, 8'h00});
    seq.rest();
    cmp("port latch", 8'h8f, latch);
    // Timer write clears the prescaler only while assigned
    for (int c = 1; c >= 0; c--)
    begin
      apb(1'b1, REG_CTRL, 32'(c));
      @(posedge mclk);
      seq.issue('{AAB_OP_SET_BIT, TIMER_ADDR, 1'b0, 3'h0, 8'h00});
      seq.rest();
      cmp("prescale clear", c[0], pclr);
    end
    // Unmapped address
    apb(1'b0, 8'h14, 32'h0);
    cmp("slverr", 1'b1, e);
    cmp("unmapped data", 32'h0, r);
    finish_test();
  end
endmodule
